// ==== dv/core_perf_event_counter_bench.sv ====
`timescale 1ns/10ps

module core_perf_event_counter_bench;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic count_enable_i = 1'b0, count_clear_i = 1'b0;
  logic [7:0] event_code_i = 8'h00, unit_mask_i = 8'h00;
  logic invert_compare_i = 1'b0;
  logic [7:0] count_threshold_i = 8'h00;
  logic core_halted_i = 1'b0, other_core_halted_i = 1'b0;
  logic bus_tick_i = 1'b0, l2_refusal_i = 1'b0, other_l2_refusal_i = 1'b0;
  logic l1_to_l2_req_i = 1'b0, l2_prefetch_req_i = 1'b0;
  logic bus_txn_pending_i = 1'b0, snoop_resp_valid_i = 1'b0;
  logic [1:0] snoop_resp_i = 2'h0;
  logic [2:0] dispatch_uops_i = 3'h0;
  logic pf_valid_i = 1'b0;
  logic [31:0] pf_addr_i = 32'h0;
  logic other_pf_taken_i = 1'b0, snoop_req_i = 1'b0, snoop_share_i = 1'b0;
  logic store_req_i = 1'b0;
  logic [3:0] busy_len = 4'h0;
  logic pf_ready_o, l2_pf_valid_o, l2_busy_i, snoop_grant_o, store_grant_o;
  logic [31:0] l2_pf_addr_o, acc_addr;
  logic [39:0] counter_o;
  logic [7:0] acc_cnt;
  logic [1:0] tick_ph = 2'h0;
  int err_total = 0;
  int comparisons = 0;

  core_perf_event_counter core_perf_event_counter_i (.clk_i(clk_i),
    .rst_b_i(rst_b_i), .count_enable_i(count_enable_i),
    .count_clear_i(count_clear_i), .event_code_i(event_code_i),
    .unit_mask_i(unit_mask_i), .invert_compare_i(invert_compare_i),
    .count_threshold_i(count_threshold_i), .core_halted_i(core_halted_i),
    .other_core_halted_i(other_core_halted_i), .bus_tick_i(bus_tick_i),
    .l2_refusal_i(l2_refusal_i), .other_l2_refusal_i(other_l2_refusal_i),
    .l1_to_l2_req_i(l1_to_l2_req_i), .l2_prefetch_req_i(l2_prefetch_req_i),
    .bus_txn_pending_i(bus_txn_pending_i),
    .snoop_resp_valid_i(snoop_resp_valid_i), .snoop_resp_i(snoop_resp_i),
    .dispatch_uops_i(dispatch_uops_i), .pf_valid_i(pf_valid_i),
    .pf_addr_i(pf_addr_i), .pf_ready_o(pf_ready_o),
    .l2_pf_valid_o(l2_pf_valid_o), .l2_pf_addr_o(l2_pf_addr_o),
    .l2_busy_i(l2_busy_i), .other_pf_taken_i(other_pf_taken_i),
    .snoop_req_i(snoop_req_i), .snoop_share_i(snoop_share_i),
    .store_req_i(store_req_i), .snoop_grant_o(snoop_grant_o),
    .store_grant_o(store_grant_o), .counter_o(counter_o));

  l2_port_model l2_port_model_i (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .l2_pf_valid_i(l2_pf_valid_o), .l2_pf_addr_i(l2_pf_addr_o),
    .busy_len_i(busy_len), .l2_busy_o(l2_busy_i), .acc_cnt_o(acc_cnt),
    .acc_addr_o(acc_addr));

  always #2 clk_i = ~clk_i;

  // bus clock as one pulse every fourth core cycle
  always @(posedge clk_i) begin
    #1;
    tick_ph = tick_ph + 2'h1;
    bus_tick_i = (tick_ph == 2'h0);
  end

  task automatic report_and_stop;
    $display("errors %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [39:0] got, input logic [39:0] exp,
                     input string what);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask : chk

  task automatic cfg(input logic [7:0] code, input logic [7:0] um,
                     input logic invert, input logic [7:0] thr);
    event_code_i = code;
    unit_mask_i = um;
    invert_compare_i = invert;
    count_threshold_i = thr;
  endtask : cfg

  // clear, count for n edges, then freeze and compare
  task automatic measure(input int n, input logic [39:0] exp);
    count_clear_i = 1'b1;
    @(posedge clk_i);
    #1;
    count_clear_i = 1'b0;
    count_enable_i = 1'b1;
    repeat (n) @(posedge clk_i);
    #1;
    count_enable_i = 1'b0;
    chk(counter_o, exp, "count");
  endtask : measure

  task automatic disp(input logic [2:0] u, input logic invert,
                      input logic [7:0] thr, input logic [39:0] exp);
    cfg(8'ha0, 8'h00, invert, thr);
    dispatch_uops_i = u;
    measure(8, exp);
  endtask : disp

  // three back-to-back prefetches, valid held between them
  task automatic pf_burst(input logic [3:0] blen);
    logic rdy;
    logic [7:0] base;
    int k;
    busy_len = blen;
    base = acc_cnt;
    count_clear_i = 1'b1;
    @(posedge clk_i);
    #1;
    count_clear_i = 1'b0;
    count_enable_i = 1'b1;
    pf_valid_i = 1'b1;
    for (int a = 0; a < 3; a++) begin
      pf_addr_i = 32'h1000_0040 + 32'(a * 64) + {28'h0, blen};
      k = 0;
      do begin
        rdy = pf_ready_o;
        @(posedge clk_i);
        #1;
        k++;
      end while (!rdy && k < 50);
      if (!rdy) begin
        err_total++;
        $display("[ERR] %0t prefetch request never taken", $time);
      end
    end
    pf_valid_i = 1'b0;
    k = 0;
    while (l2_pf_valid_o !== 1'b0 && k < 50) begin
      @(posedge clk_i);
      #1;
      k++;
    end
    if (l2_pf_valid_o !== 1'b0) begin
      err_total++;
      $display("[ERR] %0t prefetch offer never accepted", $time);
    end
    count_enable_i = 1'b0;
    chk(counter_o, 40'h3, "prefetch count");
    chk({32'h0, acc_cnt - base}, 40'h3, "accepted");
    chk({8'h0, acc_addr}, {8'h0, pf_addr_i}, "last addr");
  endtask : pf_burst

  initial begin
    repeat (10) @(posedge clk_i);
    #1;
    rst_b_i = 1'b1;
    chk(counter_o, 40'h0, "reset count");
    chk({39'h0, pf_ready_o}, 40'h1, "reset ready");
    chk({39'h0, l2_pf_valid_o}, 40'h0, "reset offer");
    cfg(8'h30, 8'h00, 1'b0, 8'h00);
    l2_refusal_i = 1'b1;
    other_l2_refusal_i = 1'b1;
    measure(8, 40'h8);
    cfg(8'h30, 8'hc0, 1'b0, 8'h00);
    measure(8, 40'h10);
    l2_refusal_i = 1'b0;
    other_l2_refusal_i = 1'b0;
    cfg(8'h32, 8'h00, 1'b0, 8'h00);
    measure(8, 40'h8);
    l1_to_l2_req_i = 1'b1;
    measure(8, 40'h0);
    l1_to_l2_req_i = 1'b0;
    l2_prefetch_req_i = 1'b1;
    measure(8, 40'h0);
    l2_prefetch_req_i = 1'b0;
    cfg(8'h3c, 8'h00, 1'b0, 8'h00);
    measure(8, 40'h8);
    core_halted_i = 1'b1;
    measure(8, 40'h0);
    cfg(8'h3c, 8'h00, 1'b1, 8'h01);
    measure(8, 40'h0);
    cfg(8'h3c, 8'h01, 1'b0, 8'h00);
    measure(8, 40'h0);
    other_core_halted_i = 1'b1;
    cfg(8'h3c, 8'h02, 1'b0, 8'h00);
    measure(8, 40'h0);
    core_halted_i = 1'b0;
    measure(8, 40'h2);
    other_core_halted_i = 1'b0;
    measure(8, 40'h0);
    cfg(8'h3c, 8'h01, 1'b0, 8'h00);
    measure(8, 40'h2);
    cfg(8'h7d, 8'h00, 1'b0, 8'h00);
    measure(8, 40'h2);
    bus_txn_pending_i = 1'b1;
    measure(8, 40'h0);
    cfg(8'h77, 8'h00, 1'b0, 8'h00);
    snoop_resp_valid_i = 1'b1;
    for (int r = 0; r < 4; r++) begin
      snoop_resp_i = 2'(r);
      measure(8, (r == 0) ? 40'h0 : 40'h8);
    end
    snoop_resp_valid_i = 1'b0;
    measure(8, 40'h0);
    cfg(8'h78, 8'h01, 1'b0, 8'h00);
    snoop_req_i = 1'b1;
    snoop_share_i = 1'b1;
    store_req_i = 1'b1;
    measure(8, 40'h8);
    chk({38'h0, snoop_grant_o, store_grant_o}, 40'h2, "port");
    snoop_share_i = 1'b0;
    measure(8, 40'h0);
    snoop_req_i = 1'b0;
    @(posedge clk_i);
    #1;
    chk({38'h0, snoop_grant_o, store_grant_o}, 40'h1, "port");
    disp(3'h3, 1'b0, 8'h00, 40'h18);
    disp(3'h3, 1'b0, 8'h01, 40'h8);
    disp(3'h3, 1'b1, 8'h01, 40'h0);
    disp(3'h0, 1'b1, 8'h01, 40'h8);
    disp(3'h0, 1'b0, 8'h01, 40'h0);
    disp(3'h3, 1'b0, 8'h03, 40'h8);
    disp(3'h3, 1'b0, 8'h04, 40'h0);
    disp(3'h3, 1'b1, 8'h04, 40'h8);
    cfg(8'h4f, 8'h00, 1'b0, 8'h00);
    pf_burst(4'h0);
    pf_burst(4'h2);
    other_pf_taken_i = 1'b1;
    measure(8, 40'h0);
    cfg(8'h4f, 8'hc0, 1'b0, 8'h00);
    measure(8, 40'h8);
    report_and_stop();
  end

  initial begin
    #(4 * 20000);
    err_total++;
    report_and_stop();
  end
endmodule : core_perf_event_counter_bench

// ==== dv/l2_port_model.sv ====
`timescale 1ns/10ps

module l2_port_model (
  input wire logic clk_i, // core clock
  input wire logic rst_b_i, // async reset, active low
  input wire logic l2_pf_valid_i, // offered prefetch
  input wire logic [31:0] l2_pf_addr_i, // offered line address
  input wire logic [3:0] busy_len_i, // refused cycles per offer
  output logic l2_busy_o, // refuse offer this cycle
  output logic [7:0] acc_cnt_o, // prefetches accepted
  output logic [31:0] acc_addr_o // last accepted address
);
  logic [3:0] wait_cnt;

  // refuse the first busy_len_i cycles of every offer
  assign l2_busy_o = l2_pf_valid_i && (wait_cnt < busy_len_i);

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wait_cnt <= 4'h0;
      acc_cnt_o <= 8'h00;
      acc_addr_o <= 32'h0;
    end else if (l2_pf_valid_i && l2_busy_o) begin
      wait_cnt <= wait_cnt + 4'h1;
    end else if (l2_pf_valid_i) begin
      wait_cnt <= 4'h0;
      acc_cnt_o <= acc_cnt_o + 8'h01;
      acc_addr_o <= l2_pf_addr_i;
    end
  end
endmodule : l2_port_model

// ==== logic/core_perf_event_counter.sv ====
`timescale 1ns/10ps
`include "perf_event_defines.svh"

module core_perf_event_counter
  import perf_event_pkg::*;
#(
  parameter int CNT_W = 40,
  parameter int ADDR_W = 32,
  parameter int UOP_W = 3
) (
  input wire logic clk_i, // core clock, 250 MHz
  input wire logic rst_b_i, // async reset, active low
  input wire logic count_enable_i, // counter runs
  input wire logic count_clear_i, // counter returns to zero
  input wire logic [7:0] event_code_i, // selected event
  input wire logic [7:0] unit_mask_i, // sub-select and core field
  input wire logic invert_compare_i, // invert threshold compare
  input wire logic [7:0] count_threshold_i, // threshold, 0 = raw add
  input wire logic core_halted_i, // this core halted by halt_instruction
  input wire logic other_core_halted_i, // other core halted
  input wire logic bus_tick_i, // one-cycle pulse per bus clock cycle
  input wire logic l2_refusal_i, // l2 refuses new access requests
  input wire logic other_l2_refusal_i, // same, other core's requests
  input wire logic l1_to_l2_req_i, // l1 request issued to l2
  input wire logic l2_prefetch_req_i, // prefetch issued to l2
  input wire logic bus_txn_pending_i, // core transaction awaits bus
  input wire logic snoop_resp_valid_i, // external snoop response seen
  input wire logic [1:0] snoop_resp_i, // response kind
  input wire logic [UOP_W-1:0] dispatch_uops_i, // micro-ops this cycle
  input wire logic pf_valid_i, // l1 data unit prefetch request
  input wire logic [ADDR_W-1:0] pf_addr_i, // prefetch line address
  output logic pf_ready_o, // prefetch request can be taken
  output logic l2_pf_valid_o, // prefetch offered to l2
  output logic [ADDR_W-1:0] l2_pf_addr_o, // offered line address
  input wire logic l2_busy_i, // l2 rejects offered prefetch
  input wire logic other_pf_taken_i, // other core took a prefetch
  input wire logic snoop_req_i, // snoop wants l1 data store port
  input wire logic snoop_share_i, // snoop is for a line other core needs
  input wire logic store_req_i, // store wants l1 data store port
  output logic snoop_grant_o, // store port given to snoop
  output logic store_grant_o, // store port given to store
  output logic [CNT_W-1:0] counter_o // event count
);

  localparam int RAW_W = (UOP_W > 2) ? UOP_W + 1 : 3;

  logic [RAW_W-1:0] raw_count;
  logic [CNT_W-1:0] next_count;
  logic [CNT_W-1:0] increment;
  logic pf_taken;
  logic all_cores;
  logic core_active_cycle;
  logic bus_active_cycle;
  logic halted_cycle_event;

  // event code and optional sub-select match
  function automatic logic ev_match(input logic [7:0] code,
                                    input logic [5:0] sub,
                                    input logic [7:0] want_code,
                                    input logic [5:0] want_sub,
                                    input logic check_sub);
    ev_match = (code == want_code) && (!check_sub || sub == want_sub);
  endfunction : ev_match

  function automatic logic [RAW_W-1:0] bit_count(input logic b);
    bit_count = {{(RAW_W-1){1'b0}}, b};
  endfunction : bit_count

  prefetch_retry #(
    .ADDR_W(ADDR_W)
  ) u_prefetch_retry (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .pf_valid_i(pf_valid_i),
    .pf_addr_i(pf_addr_i),
    .pf_ready_o(pf_ready_o),
    .l2_valid_o(l2_pf_valid_o),
    .l2_addr_o(l2_pf_addr_o),
    .l2_busy_i(l2_busy_i),
    .pf_taken_o(pf_taken)
  );

  // snoops take the store port first; the store waits
  assign snoop_grant_o = snoop_req_i;
  assign store_grant_o = store_req_i && !snoop_req_i;

  assign all_cores =
    (unit_mask_i[`CORE_SEL_MSB:`CORE_SEL_LSB] == `CORE_SEL_ALL);
  // halted core never counts cycle events, snooped or not
  assign core_active_cycle = !core_halted_i;
  assign bus_active_cycle = bus_tick_i && !core_halted_i;

  // per-cycle count of the selected event
  always_comb begin
    raw_count = '0;
    if (ev_match(event_code_i, unit_mask_i[5:0], `EV_L2_REFUSAL,
                 6'h00, 1'b0)) begin
      raw_count = bit_count(l2_refusal_i)
                + bit_count(all_cores && other_l2_refusal_i);
    end else if (ev_match(event_code_i, unit_mask_i[5:0], `EV_L2_IDLE_REQ,
                          6'h00, 1'b0)) begin
      raw_count = bit_count(!l1_to_l2_req_i && !l2_prefetch_req_i);
    end else if (ev_match(event_code_i, unit_mask_i[5:0], `EV_UNHALTED,
                          `UM_CORE_CYCLES, 1'b1)) begin
      raw_count = bit_count(core_active_cycle);
    end else if (ev_match(event_code_i, unit_mask_i[5:0], `EV_UNHALTED,
                          `UM_REF_CYCLES, 1'b1)) begin
      raw_count = bit_count(bus_active_cycle);
    end else if (ev_match(event_code_i, unit_mask_i[5:0], `EV_UNHALTED,
                          `UM_SERIAL_CYCLES, 1'b1)) begin
      raw_count = bit_count(bus_active_cycle && other_core_halted_i);
    end else if (ev_match(event_code_i, unit_mask_i[5:0], `EV_L1_PREFETCH,
                          `UM_PREFETCH, 1'b1)) begin
      raw_count = bit_count(pf_taken)
                + bit_count(all_cores && other_pf_taken_i);
    end else if (ev_match(event_code_i, unit_mask_i[5:0], `EV_SNOOP_SHARE,
                          `UM_SNOOP_SHARE, 1'b1)) begin
      raw_count = bit_count(snoop_req_i && snoop_share_i);
    end else if (ev_match(event_code_i, unit_mask_i[5:0], `EV_BUS_IDLE,
                          `UM_BUS_IDLE, 1'b1)) begin
      raw_count = bit_count(bus_tick_i && !bus_txn_pending_i);
    end else if (ev_match(event_code_i, unit_mask_i[5:0], `EV_BUS_SNOOP,
                          6'h00, 1'b0)) begin
      raw_count = bit_count(snoop_resp_valid_i &&
                            snoop_resp_i != resp_none);
    end else if (ev_match(event_code_i, unit_mask_i[5:0], `EV_DISPATCH,
                          6'h00, 1'b0)) begin
      raw_count = RAW_W'(dispatch_uops_i);
    end
  end

  // an inverted threshold must not count a halted cycle either
  assign halted_cycle_event =
    core_halted_i && (event_code_i == `EV_UNHALTED);

  // threshold stage turns per-cycle counts into cycle counts when the threshold is nonzero; 0 adds the raw count
  always_comb begin
    if (halted_cycle_event) begin
      increment = '0;
    end else if (count_threshold_i == 8'h00) begin
      increment = CNT_W'(raw_count);
    end else if (invert_compare_i) begin
      increment = CNT_W'(8'(raw_count) < count_threshold_i);
    end else begin
      increment = CNT_W'(8'(raw_count) >= count_threshold_i);
    end
  end

  always_comb begin
    if (count_clear_i) begin
      next_count = '0;
    end else if (count_enable_i) begin
      next_count = counter_o + increment;
    end else begin
      next_count = counter_o;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      counter_o <= CNT_W'(`COUNT_RESET);
    end else begin
      counter_o <= next_count;
    end
  end

  // checks
  logic plain_add;
  assign plain_add = count_enable_i && !count_clear_i &&
                     count_threshold_i == 8'h00;

  chk_l2_refusal: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (plain_add && event_code_i == `EV_L2_REFUSAL && !all_cores) |=>
      counter_o == $past(counter_o) + CNT_W'($past(l2_refusal_i)))
    else $error("l2 refusal count wrong");

  chk_l2_idle: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (plain_add && event_code_i == `EV_L2_IDLE_REQ &&
     (l1_to_l2_req_i || l2_prefetch_req_i)) |=>
      counter_o == $past(counter_o))
    else $error("l2 idle count moved during a request");

  chk_core_cycles: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (plain_add && event_code_i == `EV_UNHALTED &&
     unit_mask_i[5:0] == `UM_CORE_CYCLES && !core_halted_i)[*2] |=>
      counter_o == $past(counter_o, 2) + CNT_W'(2))
    else $error("core cycle count not one per cycle");

  chk_halt_frozen: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (count_enable_i && !count_clear_i && core_halted_i &&
     event_code_i == `EV_UNHALTED) |=> counter_o == $past(counter_o))
    else $error("cycle event advanced on halted core");

  chk_ref_cycles: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (plain_add && event_code_i == `EV_UNHALTED &&
     unit_mask_i[5:0] == `UM_REF_CYCLES) |=>
      counter_o == $past(counter_o) +
        CNT_W'($past(bus_tick_i) && !$past(core_halted_i)))
    else $error("reference cycle count wrong");

  chk_serial_cycles: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (plain_add && event_code_i == `EV_UNHALTED &&
     unit_mask_i[5:0] == `UM_SERIAL_CYCLES && !other_core_halted_i) |=>
      counter_o == $past(counter_o))
    else $error("serial cycles counted while other core ran");

  chk_prefetch_cnt: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (plain_add && event_code_i == `EV_L1_PREFETCH && !all_cores &&
     unit_mask_i[5:0] == `UM_PREFETCH && pf_valid_i && pf_ready_o) |=>
      counter_o == $past(counter_o) + CNT_W'(1))
    else $error("prefetch request not counted");

  chk_snoop_share: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (plain_add && event_code_i == `EV_SNOOP_SHARE &&
     unit_mask_i[5:0] == `UM_SNOOP_SHARE) |=>
      counter_o == $past(counter_o) +
        CNT_W'($past(snoop_req_i) && $past(snoop_share_i)))
    else $error("snoop to share count wrong");

  chk_store_port: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    snoop_req_i |-> (snoop_grant_o && !store_grant_o))
    else $error("store port granted to store during snoop");

  chk_bus_idle: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (plain_add && event_code_i == `EV_BUS_IDLE &&
     unit_mask_i[5:0] == `UM_BUS_IDLE && bus_txn_pending_i) |=>
      counter_o == $past(counter_o))
    else $error("bus idle counted with pending transaction");

  chk_bus_snoop: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (plain_add && event_code_i == `EV_BUS_SNOOP && snoop_resp_valid_i &&
     snoop_resp_i == resp_hit_modified) |=>
      counter_o == $past(counter_o) + CNT_W'(1))
    else $error("hit-modified response not counted");

  chk_no_dispatch: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (count_enable_i && !count_clear_i && event_code_i == `EV_DISPATCH &&
     invert_compare_i && count_threshold_i == 8'h01) |=>
      counter_o == $past(counter_o) +
        CNT_W'($past(dispatch_uops_i) == '0))
    else $error("stall cycle count wrong");

  chk_dispatch_on: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (count_enable_i && !count_clear_i && event_code_i == `EV_DISPATCH &&
     !invert_compare_i && count_threshold_i == 8'h01) |=>
      counter_o == $past(counter_o) +
        CNT_W'($past(dispatch_uops_i) != '0))
    else $error("issuing cycle count wrong");

  chk_raw_add: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (plain_add && event_code_i == `EV_DISPATCH) |=>
      counter_o == $past(counter_o) + CNT_W'($past(dispatch_uops_i)))
    else $error("raw dispatch count not added");

  chk_all_cores: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (plain_add && event_code_i == `EV_L2_REFUSAL && all_cores &&
     l2_refusal_i && other_l2_refusal_i) |=>
      counter_o == $past(counter_o) + CNT_W'(2))
    else $error("all-core refusal count wrong");

  chk_l2_idle_add: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (plain_add && event_code_i == `EV_L2_IDLE_REQ &&
     !l1_to_l2_req_i && !l2_prefetch_req_i) |=>
      counter_o == $past(counter_o) + CNT_W'(1))
    else $error("l2 idle cycle not counted");

  chk_serial_add: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (plain_add && event_code_i == `EV_UNHALTED &&
     unit_mask_i[5:0] == `UM_SERIAL_CYCLES && bus_tick_i &&
     !core_halted_i && other_core_halted_i) |=>
      counter_o == $past(counter_o) + CNT_W'(1))
    else $error("serial bus cycle not counted");

  chk_bus_idle_add: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (plain_add && event_code_i == `EV_BUS_IDLE &&
     unit_mask_i[5:0] == `UM_BUS_IDLE && bus_tick_i &&
     !bus_txn_pending_i) |=>
      counter_o == $past(counter_o) + CNT_W'(1))
    else $error("idle bus cycle not counted");

  chk_thr_meet: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (count_enable_i && !count_clear_i && event_code_i == `EV_DISPATCH &&
     !invert_compare_i && count_threshold_i != 8'h00) |=>
      counter_o == $past(counter_o) +
        CNT_W'(8'($past(dispatch_uops_i)) >= $past(count_threshold_i)))
    else $error("threshold meet count wrong");

  chk_thr_miss: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (count_enable_i && !count_clear_i && event_code_i == `EV_DISPATCH &&
     invert_compare_i && count_threshold_i != 8'h00) |=>
      counter_o == $past(counter_o) +
        CNT_W'(8'($past(dispatch_uops_i)) < $past(count_threshold_i)))
    else $error("inverted threshold count wrong");

endmodule : core_perf_event_counter

// ==== logic/perf_event_defines.svh ====
`ifndef PERF_EVENT_DEFINES_SVH
`define PERF_EVENT_DEFINES_SVH

// event codes
`define EV_L2_REFUSAL 8'h30
`define EV_L2_IDLE_REQ 8'h32
`define EV_UNHALTED 8'h3c
`define EV_L1_PREFETCH 8'h4f
`define EV_BUS_SNOOP 8'h77
`define EV_SNOOP_SHARE 8'h78
`define EV_BUS_IDLE 8'h7d
`define EV_DISPATCH 8'ha0

// unit mask sub-selects (low six bits)
`define UM_CORE_CYCLES 6'h00
`define UM_REF_CYCLES 6'h01
`define UM_SERIAL_CYCLES 6'h02
`define UM_PREFETCH 6'h00
`define UM_SNOOP_SHARE 6'h01
`define UM_BUS_IDLE 6'h00

// core specificity field in the unit mask
`define CORE_SEL_MSB 7
`define CORE_SEL_LSB 6
`define CORE_SEL_ALL 2'h3

// reset values
`define COUNT_RESET 0
`define PF_ADDR_RESET 0

`endif

// ==== logic/perf_event_pkg.sv ====
package perf_event_pkg;

  typedef enum logic [1:0] {
    resp_none,
    resp_clean,
    resp_hit,
    resp_hit_modified
  } snoop_resp_type;

  typedef enum logic {
    pf_idle,
    pf_hold
  } pf_state_type;

endpackage : perf_event_pkg

// ==== logic/prefetch_retry.sv ====
`timescale 1ns/10ps
`include "perf_event_defines.svh"

module prefetch_retry
  import perf_event_pkg::*;
#(
  parameter int ADDR_W = 32
) (
  input wire logic clk_i, // core clock
  input wire logic rst_b_i, // async reset, active low
  input wire logic pf_valid_i, // prefetch request from l1 data unit
  input wire logic [ADDR_W-1:0] pf_addr_i, // line address of request
  output logic pf_ready_o, // request can be taken
  output logic l2_valid_o, // request presented to second-level cache
  output logic [ADDR_W-1:0] l2_addr_o, // presented line address
  input wire logic l2_busy_i, // second-level cache rejects this cycle
  output logic pf_taken_o // one-cycle pulse per new request
);

  pf_state_type state;

  assign pf_ready_o = (state == pf_idle);
  assign l2_valid_o = (state == pf_hold);
  assign pf_taken_o = pf_ready_o && pf_valid_i;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= pf_idle;
    end else begin
      case (state)
        pf_idle: begin
          if (pf_valid_i) begin
            state <= pf_hold;
          end
        end
        pf_hold: begin
          // a rejected request stays up and is offered again
          if (!l2_busy_i) begin
            state <= pf_idle;
          end
        end
        default: begin
          state <= pf_idle;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      l2_addr_o <= ADDR_W'(`PF_ADDR_RESET);
    end else if (pf_taken_o) begin
      l2_addr_o <= pf_addr_i;
    end
  end

  chk_retry_holds: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (l2_valid_o && l2_busy_i) |=>
      (l2_valid_o && l2_addr_o == $past(l2_addr_o)))
    else $error("rejected prefetch was not offered again");

endmodule : prefetch_retry
